// file: hfa_pkg.sv
// constants, carriers and state types for the frame aligner
package hfa_pkg;
   localparam int FRAME_BITS = 512;
   localparam int FAW_BITS = 8;
   localparam int FRAME_BYTES = FRAME_BITS / FAW_BITS;
   localparam int RING_AW = 11;
   localparam int GROUP = 8;
   localparam logic [10:0] FILL_BYTES = 11'h600;
   localparam logic [4:0] LAST_READ = 5'h17;
   localparam logic [5:0] LAST_OFFSET = 6'h3F;
   localparam logic [8:0] DATA_FIRST = 9'h001;
   localparam logic [8:0] DATA_LAST = 9'h1ED;
   localparam logic [1:0] CONFIRM_LAST = 2'h3;
   localparam logic [7:0] FAW_PATTERN = 8'h1B;
   localparam int CLK_MHZ = 25;
   localparam int SEARCH_US = 250;
   localparam int SEARCH_CYCLES = SEARCH_US * CLK_MHZ;
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam int IGNORE_BIT = 0;
   localparam int LOCK_BIT = 0;
   localparam int LOF_BIT = 1;
   localparam int OVF_BIT = 2;
   localparam logic CTRL_IGNORE_RST = 1'b0;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } hfa_apb_t;

   typedef struct packed {
      logic [14:0] buffer_addr;
      logic [7:0]  buffer_data;
      logic        buffer_data_oe;
      logic        buffer_write_n;
      logic        buffer_select_n;
      logic        buffer_output_enable_n;
   } hfa_ram_t;

   localparam hfa_ram_t RAM_IDLE = '{15'h0000, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1};

   typedef enum logic [2:0] {
      ST_SCAN = 3'b001, ST_LOCK = 3'b010, ST_CONFIRM = 3'b100
   } hfa_align_t;

   typedef enum logic [2:0] {
      M_IDLE = 3'b001, M_WR = 3'b010, M_RD = 3'b100
   } hfa_mem_t;
endpackage : hfa_pkg

// file: hfa_frame_aligner.sv
// frame alignment front end: line capture, buffer ram, search and monitor
module hfa_frame_aligner #(
   parameter int SEARCH_LIMIT = hfa_pkg::SEARCH_CYCLES
) (
   input  wire logic             core_clk_in,
   input  wire logic             arst_n_in,
   input  wire logic             line_data_in,
   input  wire logic             line_valid_n_in,
   input  wire logic             line_strobe_in,
   input  wire logic             output_float_n_in,
   input  wire logic [7:0]       buffer_data_in,
   input  wire hfa_pkg::hfa_apb_t apb_in,
   output logic [31:0]           prdata_out,
   output logic                  pready_out,
   output logic                  pslverr_out,
   output logic                  line_ready_n_out,
   output hfa_pkg::hfa_ram_t     buffer_out,
   output logic                  fault_n_out,
   output logic                  picture_status_flag_n_out,
   output logic                  frame_lock_out,
   output logic                  outputs_oe_out,
   output logic                  data_bit_out,
   output logic                  data_strobe_out
);
   import hfa_pkg::*;

   logic [2:0]     stb_s_r;
   logic [1:0]     dat_s_r;
   logic [1:0]     val_s_r;
   logic [1:0]     flt_s_r;
   logic [7:0]     sh_r;
   logic [2:0]     bitn_r;
   logic [10:0]    wp_r;
   logic           wr_pend_r;
   logic [10:0]    wr_addr_r;
   logic [7:0]     wr_data_r;
   logic [10:0]    fill_r;
   logic           filled_r;
   hfa_mem_t       mem_r;
   hfa_ram_t       ram_r;
   logic           rd_ok_r;
   logic [7:0]     rdata_r;
   hfa_align_t     st_r;
   logic [1:0]     cnt_r;
   logic [8:0]     phase_r;
   logic [2:0]     radj_r;
   logic [10:0]    base_r;
   logic [5:0]     boff_r;
   logic [4:0]     k_r;
   logic           rd_busy_r;
   logic           eval_r;
   logic [7:0]     cap_r [GROUP];
   logic [7:0]     mask_r;
   logic           ign_r;
   logic           stat_lof_r;
   logic           stat_ovf_r;
   logic [31:0]    prdata_r;
   logic           pready_r;
   logic           pslverr_r;
   logic           ready_n_r;
   logic           fault_n_r;
   logic           lock_r;
   logic           oe_r;
   logic           dbit_r;
   logic           dstb_r;
   logic [15:0]    scan_cyc_r;

   logic           dat;
   logic           cap;
   logic           byte_done;
   logic           wr_go;
   logic           rd_req;
   logic           rd_go;
   logic           ovf_evt;
   logic [8:0]     q;
   logic [10:0]    fdist;
   logic           exp_bit;
   logic           chk;
   logic           good;
   logic           lof_evt;
   logic [10:0]    rd_addr;
   logic [10:0]    pb;
   logic           hit;
   logic [2:0]     hit_j;
   logic [2:0]     hit_rot;
   logic           apb_acc;
   logic           wr_ctrl;
   logic           wr_stat;

   // rotation of the alignment pattern that a column matches, if any
   function automatic logic [3:0] rot_fn(input logic [7:0] col);
      logic [3:0] res;
      logic       ok;
      res = 4'h0;
      for (int r = 0; r < FAW_BITS; r++) begin
         ok = 1'b1;
         for (int k = 0; k < FAW_BITS; k++) begin
            if (col[k] != FAW_PATTERN[3'(7 - ((r + k) % 8))]) begin
               ok = 1'b0;
            end
         end
         if (ok) begin
            res = {1'b1, 3'(r)};
         end
      end
      return res;
   endfunction : rot_fn

   // pins from the line pass two flops before use
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stb_s_r <= 3'h0;
         dat_s_r <= 2'h0;
         val_s_r <= 2'h3;
         flt_s_r <= 2'h0;
      end else begin
         stb_s_r <= {stb_s_r[1:0], line_strobe_in};
         dat_s_r <= {dat_s_r[0], line_data_in};
         val_s_r <= {val_s_r[0], line_valid_n_in};
         flt_s_r <= {flt_s_r[0], output_float_n_in};
      end
   end

   assign dat = dat_s_r[1];
   assign cap = stb_s_r[1] & ~stb_s_r[2] & ~val_s_r[1];
   assign byte_done = cap & (bitn_r == 3'h7);
   assign wr_go = (mem_r == M_IDLE) & wr_pend_r;
   assign ovf_evt = byte_done & wr_pend_r & ~wr_go;

   // shift in captured bits, count bits, advance ring write address per byte
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sh_r <= 8'h00;
         bitn_r <= 3'h0;
         wp_r <= 11'h000;
      end else if (cap) begin
         sh_r <= {sh_r[6:0], dat};
         bitn_r <= bitn_r + 3'h1;
         if (bitn_r == 3'h7) begin
            wp_r <= wp_r + 11'h001;
         end
      end
   end

   // write request; a new byte wins over the grant clear
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 11'h000;
         wr_data_r <= 8'h00;
      end else begin
         wr_pend_r <= byte_done | (wr_pend_r & ~wr_go);
         if (byte_done) begin
            wr_addr_r <= wp_r;
            wr_data_r <= {sh_r[6:0], dat};
         end
      end
   end

   // search waits for 24 frames in the ring
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fill_r <= 11'h000;
         filled_r <= 1'b0;
      end else if (wr_go && !filled_r) begin
         fill_r <= fill_r + 11'h001;
         filled_r <= (fill_r == FILL_BYTES - 11'h001);
      end
   end

   // ram cycles: one-cycle write, one-cycle read
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mem_r <= M_IDLE;
         ram_r <= RAM_IDLE;
         rd_ok_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         ram_r <= RAM_IDLE;
         rd_ok_r <= 1'b0;
         mem_r <= M_IDLE;
         case (mem_r)
            M_IDLE: begin
               if (wr_go) begin
                  ram_r.buffer_addr <= {4'h0, wr_addr_r};
                  ram_r.buffer_data <= wr_data_r;
                  // float keeps the data bus released
                  ram_r.buffer_data_oe <= flt_s_r[1];
                  ram_r.buffer_write_n <= 1'b0;
                  ram_r.buffer_select_n <= 1'b0;
                  mem_r <= M_WR;
               end else if (rd_go) begin
                  ram_r.buffer_addr <= {4'h0, rd_addr};
                  ram_r.buffer_select_n <= 1'b0;
                  ram_r.buffer_output_enable_n <= 1'b0;
                  mem_r <= M_RD;
               end
            end
            M_WR: mem_r <= M_IDLE;
            M_RD: begin
               rd_ok_r <= 1'b1;
               rdata_r <= buffer_data_in;
            end
            default: mem_r <= M_IDLE;
         endcase
      end
   end

   // candidate offsets walked over every bit of a frame
   assign rd_addr = 11'(base_r + {5'h00, boff_r} + {k_r, 6'h00});
   assign rd_req = (st_r == ST_SCAN) & filled_r & ~rd_busy_r & ~eval_r;
   assign rd_go = (mem_r == M_IDLE) & ~wr_pend_r & rd_req;
   assign pb = 11'(base_r + {5'h00, boff_r});

   always_comb begin
      logic [7:0] col;
      logic [3:0] m;
      col = 8'h00;
      m = 4'h0;
      hit = 1'b0;
      hit_j = 3'h0;
      hit_rot = 3'h0;
      for (int j = 7; j >= 0; j--) begin
         for (int k = 0; k < GROUP; k++) begin
            col[k] = cap_r[k][j];
         end
         m = rot_fn(col);
         if (mask_r[j] && m[3]) begin
            hit = 1'b1;
            hit_j = 3'(j);
            hit_rot = m[2:0];
         end
      end
   end

   // later groups must repeat the first one bit for bit
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         base_r <= 11'h000;
         boff_r <= 6'h00;
         k_r <= 5'h00;
         rd_busy_r <= 1'b0;
         eval_r <= 1'b0;
         mask_r <= 8'hFF;
         for (int i = 0; i < GROUP; i++) begin
            cap_r[i] <= 8'h00;
         end
      end else begin
         // oldest byte trails the writer by 24 frames
         // frozen once the first read of a sweep goes out
         if (boff_r == 6'h00 && k_r == 5'h00 && !rd_busy_r &&
             !eval_r && !rd_go) begin
            base_r <= 11'(wp_r - FILL_BYTES);
         end
         if (rd_go) begin
            rd_busy_r <= 1'b1;
         end
         if (rd_ok_r) begin
            rd_busy_r <= 1'b0;
            if (k_r < 5'(GROUP)) begin
               cap_r[k_r[2:0]] <= rdata_r;
            end else begin
               mask_r <= mask_r & ~(rdata_r ^ cap_r[k_r[2:0]]);
            end
            if (k_r == LAST_READ) begin
               eval_r <= 1'b1;
               k_r <= 5'h00;
            end else begin
               k_r <= k_r + 5'h01;
            end
         end
         if (eval_r) begin
            eval_r <= 1'b0;
            mask_r <= 8'hFF;
            boff_r <= hit ? 6'h00 : boff_r + 6'h01;
         end
      end
   end

   // alignment bit found by frame phase
   assign q = 9'({wp_r[5:0], bitn_r} - phase_r);
   assign fdist = 11'(wp_r - {5'h00, phase_r[8:3]});
   assign exp_bit = FAW_PATTERN[3'(3'h7 - 3'(radj_r + fdist[8:6]))];
   assign chk = cap & (q == 9'h000) & (st_r != ST_SCAN);
   assign good = (dat == exp_bit);
   assign lof_evt = (st_r == ST_CONFIRM) & chk & ~good;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_r <= ST_SCAN;
         cnt_r <= 2'h0;
         phase_r <= 9'h000;
         radj_r <= 3'h0;
      end else begin
         case (st_r)
            ST_SCAN: begin
               if (eval_r && hit) begin
                  phase_r <= {pb[5:0], 3'(3'h7 - hit_j)};
                  radj_r <= 3'(hit_rot - pb[8:6]);
                  st_r <= ST_LOCK;
               end
            end
            ST_LOCK: begin
               if (chk && !good) begin
                  cnt_r <= 2'h0;
                  st_r <= ST_CONFIRM;
               end
            end
            ST_CONFIRM: begin
               if (chk) begin
                  // a second error in four: new search
                  if (!good) begin
                     st_r <= ST_SCAN;
                  end else if (cnt_r == CONFIRM_LAST) begin
                     st_r <= ST_LOCK;
                  end else begin
                     cnt_r <= cnt_r + 2'h1;
                  end
               end
            end
            default: st_r <= ST_SCAN;
         endcase
      end
   end

   // only fill bit and data pass unless ign_r is set; parity dropped
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dbit_r <= 1'b0;
         dstb_r <= 1'b0;
      end else begin
         dstb_r <= cap & (ign_r | ((st_r != ST_SCAN) &
                   (q >= DATA_FIRST) & (q <= DATA_LAST)));
         if (cap) begin
            dbit_r <= dat;
         end
      end
   end

   // registers reached over the apb slave, one wait state
   assign apb_acc = apb_in.psel & apb_in.penable & pready_r;
   assign wr_ctrl = apb_acc & apb_in.pwrite & (apb_in.paddr == CTRL_OFF);
   assign wr_stat = apb_acc & apb_in.pwrite & (apb_in.paddr == STAT_OFF);

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= apb_in.psel & apb_in.penable & ~pready_r;
         if (apb_in.psel && apb_in.penable && !pready_r) begin
            pslverr_r <= (apb_in.paddr != CTRL_OFF) &&
                         (apb_in.paddr != STAT_OFF);
            case (apb_in.paddr)
               CTRL_OFF: prdata_r <= {31'h0, ign_r};
               STAT_OFF: prdata_r <= {29'h0, stat_ovf_r, stat_lof_r, lock_r};
               default:  prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ign_r <= CTRL_IGNORE_RST;
      end else if (wr_ctrl) begin
         ign_r <= apb_in.pwdata[IGNORE_BIT];
      end
   end

   // sticky status, cleared by writing one; a new event wins
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stat_lof_r <= 1'b0;
         stat_ovf_r <= 1'b0;
      end else begin
         stat_lof_r <= lof_evt |
                       (stat_lof_r & ~(wr_stat & apb_in.pwdata[LOF_BIT]));
         stat_ovf_r <= ovf_evt |
                       (stat_ovf_r & ~(wr_stat & apb_in.pwdata[OVF_BIT]));
      end
   end

   // reset clears these flops except fault_n_r, set high; pins other than ready_n idle from reset
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ready_n_r <= 1'b0;
         fault_n_r <= 1'b1;
         lock_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         // a full byte still waiting blocks the last bit of the next byte
         ready_n_r <= ~(wr_pend_r & ~wr_go & (bitn_r == 3'h7));
         fault_n_r <= ~stat_lof_r;
         lock_r <= ign_r | (st_r != ST_SCAN);
         oe_r <= flt_s_r[1];
      end
   end

   // search time watchdog for the assertion only
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scan_cyc_r <= 16'h0000;
      end else if (st_r != ST_SCAN || !filled_r ||
                   (eval_r && boff_r == LAST_OFFSET)) begin
         scan_cyc_r <= 16'h0000;
      end else begin
         scan_cyc_r <= scan_cyc_r + 16'h0001;
      end
   end

   assign prdata_out = prdata_r;
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;
   assign line_ready_n_out = ready_n_r;
   assign buffer_out = ram_r;
   assign fault_n_out = fault_n_r;
   // no picture decode here, flag held inactive
   assign picture_status_flag_n_out = 1'b1;
   assign frame_lock_out = lock_r;
   assign outputs_oe_out = oe_r;
   assign data_bit_out = dbit_r;
   assign data_strobe_out = dstb_r;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);

   sequence s_lof_report;
      stat_lof_r ##1 !fault_n_r;
   endsequence
   sequence s_write_cycle;
      !ram_r.buffer_write_n && !ram_r.buffer_select_n ##1
      ram_r.buffer_write_n;
   endsequence

   property p_lof_fault;
      lof_evt |=> s_lof_report;
   endproperty
   a_lof_fault: assert property (p_lof_fault)
      else $error("fault not raised after loss of alignment");
   property p_lock_miss;
      st_r == ST_LOCK && chk && !good |=> st_r == ST_CONFIRM;
   endproperty
   a_lock_miss: assert property (p_lock_miss)
      else $error("mismatch while locked not followed up");
   property p_confirm_bad;
      lof_evt |=> st_r == ST_SCAN && stat_lof_r;
   endproperty
   a_confirm_bad: assert property (p_confirm_bad)
      else $error("second mismatch did not restart search");
   property p_confirm_ok;
      st_r == ST_CONFIRM && chk && good && cnt_r == CONFIRM_LAST
      |=> st_r == ST_LOCK;
   endproperty
   a_confirm_ok: assert property (p_confirm_ok)
      else $error("four good bits did not keep lock");
   property p_scan_nolock;
      st_r == ST_SCAN && !ign_r |=> !lock_r;
   endproperty
   a_scan_nolock: assert property (p_scan_nolock)
      else $error("lock shown during search");
   property p_parity_drop;
      cap && !ign_r && (q == 9'h000 || q > DATA_LAST) |=> !dstb_r;
   endproperty
   a_parity_drop: assert property (p_parity_drop)
      else $error("framing or parity bit passed on");
   property p_ignore;
      ign_r ##1 ign_r |=> lock_r;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("ignore mode without lock shown");
   property p_write;
      wr_go |=> s_write_cycle;
   endproperty
   a_write: assert property (p_write)
      else $error("buffer write cycle malformed");
   property p_read;
      rd_go |=> !ram_r.buffer_output_enable_n ##1 rd_ok_r;
   endproperty
   a_read: assert property (p_read)
      else $error("buffer read not returned in two cycles");
   property p_search_time;
      scan_cyc_r < 16'(SEARCH_LIMIT);
   endproperty
   a_search_time: assert property (p_search_time)
      else $error("alignment search took too long");
   property p_capture;
      cap |=> bitn_r == 3'($past(bitn_r) + 3'h1);
   endproperty
   a_capture: assert property (p_capture)
      else $error("captured bit not counted");
endmodule : hfa_frame_aligner

// file: hfa_line_src.sv
// line source model: framed serial stream with strobe
module hfa_line_src (
   input  wire logic run_in,
   input  wire logic bad_in,
   input  wire logic line_ready_n_in,
   output logic      line_data_out,
   output logic      line_valid_n_out,
   output logic      line_strobe_out,
   output logic      sof_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import hfa_pkg::*;
   logic [15:0] lfsr_r = 16'h3A5F;
   int          pos = 137;
   int          fidx = 0;
   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_step
   initial begin
      line_data_out = 1'b0;
      line_valid_n_out = 1'b1;
      line_strobe_out = 1'b0;
      sof_out = 1'b0;
      #7;
      forever begin
         // hold off while ready is low (or unknown in reset)
         if (!run_in || line_ready_n_in !== 1'b1) begin
            line_valid_n_out = 1'b1;
            line_data_out = ~line_data_out;
            #320;
         end else begin
            lfsr_r = lfsr_step(lfsr_r);
            // pattern bit first in frame, odd start
            line_data_out = (pos != 0) ? lfsr_r[0]
                                       : FAW_PATTERN[7 - fidx] ^ bad_in;
            sof_out = (pos == 0);
            line_valid_n_out = 1'b0;
            // rising strobe 80 ns into the bit, 320 ns period
            #80 line_strobe_out = 1'b1;
            #160 line_strobe_out = 1'b0;
            #80;
            pos = (pos + 1) % FRAME_BITS;
            if (pos == 0) fidx = (fidx + 1) % FAW_BITS;
         end
      end
   end
endmodule : hfa_line_src

// file: test_h261_frame_aligner.sv
// testbench: line source, ram model, apb master and checks
module test_h261_frame_aligner;
   timeunit 1ns;
   timeprecision 1ps;
   import hfa_pkg::*;
   logic        core_clk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        float_n = 1'b0;
   logic        run = 1'b0;
   logic        bad = 1'b0;
   logic        ign_chk = 1'b0;
   logic        ldata, lvalid_n, lstrobe, sof;
   logic        pready, pslverr, ready_n, fault_n, pic_n, lock, oe;
   logic        dbit, dstb;
   logic [7:0]  bdata_in;
   logic [7:0]  ram_last_r = 8'h00;
   logic [7:0]  mem [0:2047];
   logic [31:0] prdata;
   logic [33:0] e_r;
   hfa_apb_t    apb = '0;
   hfa_ram_t    ram;
   logic [33:0] apb_q[$];
   logic        bit_q[$];
   int          n_errors = 0, checked = 0, n_out = 0, n_bits = 0, c0, n;

   always #20 core_clk_in = ~core_clk_in;

   hfa_frame_aligner i_dut (.core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in), .line_data_in(ldata),
      .line_valid_n_in(lvalid_n), .line_strobe_in(lstrobe),
      .output_float_n_in(float_n), .buffer_data_in(bdata_in),
      .apb_in(apb), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .line_ready_n_out(ready_n),
      .buffer_out(ram), .fault_n_out(fault_n),
      .picture_status_flag_n_out(pic_n), .frame_lock_out(lock),
      .outputs_oe_out(oe), .data_bit_out(dbit), .data_strobe_out(dstb));

   hfa_line_src i_src (.run_in(run), .bad_in(bad),
      .line_ready_n_in(ready_n), .line_data_out(ldata),
      .line_valid_n_out(lvalid_n), .line_strobe_out(lstrobe),
      .sof_out(sof));

   // released bus shows inverse of last read
   assign bdata_in = (!ram.buffer_select_n && !ram.buffer_output_enable_n)
                     ? mem[ram.buffer_addr[10:0]] : ~ram_last_r;
   always @(posedge core_clk_in) begin
      if (!ram.buffer_select_n && !ram.buffer_write_n)
         mem[ram.buffer_addr[10:0]] <= ram.buffer_data;
      if (!ram.buffer_select_n && !ram.buffer_output_enable_n)
         ram_last_r <= mem[ram.buffer_addr[10:0]];
   end

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_in);
   endtask : cyc

   // caller sits just after a rising edge
   task automatic apb_xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, input logic [31:0] exp, input logic err);
      int k;
      apb_q.push_back({~wr, err, exp});
      apb.psel <= 1'b1;
      apb.penable <= 1'b0;
      apb.pwrite <= wr;
      apb.paddr <= a;
      apb.pwdata <= wd;
      @(posedge core_clk_in) apb.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) n_errors++;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
      @(posedge core_clk_in);
   endtask : apb_xfer

   always @(posedge core_clk_in) begin
      if (pready === 1'b1 && apb_q.size() > 0) begin
         e_r = apb_q.pop_front();
         check("pslverr", pslverr, e_r[32]);
         if (e_r[33]) check("prdata", prdata, e_r[31:0]);
      end
      if (dstb === 1'b1) begin
         n_out++;
         if (bit_q.size() > 0) check("data bit", dbit, bit_q.pop_front());
      end
   end

   always @(posedge lstrobe) begin
      n_bits++;
      if (ign_chk) bit_q.push_back(ldata);
   end

   initial begin
      #8000000;
      n_errors++;
      print_verdict();
   end

   initial begin
      cyc(5);
      check("ready_n in reset", ready_n, 0);
      check("fault_n in reset", fault_n, 1);
      check("lock in reset", lock, 0);
      arst_n_in <= 1'b1;
      cyc(4);
      check("oe floated", oe, 0);
      float_n <= 1'b1;
      cyc(4);
      check("oe driven", oe, 1);
      check("ready_n after reset", ready_n, 1);
      check("picture flag", pic_n, 1);
      apb_xfer(1'b0, STAT_OFF, 0, 32'h0, 1'b0);
      apb_xfer(1'b0, CTRL_OFF, 0, 32'h0, 1'b0);
      apb_xfer(1'b0, 8'h08, 0, 32'h0, 1'b1);
      apb_xfer(1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1);
      apb_xfer(1'b1, CTRL_OFF, 32'h1, 32'h0, 1'b0);
      apb_xfer(1'b0, CTRL_OFF, 0, 32'h1, 1'b0);
      check("lock ignore mode", lock, 1);
      $display("test reset and registers done");
      run <= 1'b1;
      @(posedge core_clk_in iff dstb === 1'b1);
      ign_chk = 1'b1;
      repeat (40) @(posedge lstrobe);
      ign_chk = 1'b0;
      cyc(16);
      check("bits left", bit_q.size(), 0);
      apb_xfer(1'b1, CTRL_OFF, 32'h0, 32'h0, 1'b0);
      cyc(2);
      check("lock after ignore", lock, 0);
      $display("test ignore mode done");
      for (n = 0; n < 120000 && lock !== 1'b1; n++) @(posedge core_clk_in);
      check("lock found", lock, 1);
      check("bits before lock", n_bits >= FILL_BYTES * 8, 1);
      apb_xfer(1'b0, STAT_OFF, 0, 32'h1, 1'b0);
      @(posedge sof);
      c0 = n_out;
      @(posedge sof);
      check("bits per frame", n_out - c0, FRAME_BITS - 19);
      $display("test lock done");
      bad <= 1'b1;
      @(posedge sof);
      bad <= 1'b0;
      repeat (5) begin
         @(posedge sof);
         cyc(20);
         check("lock kept", lock, 1);
         check("fault_n kept", fault_n, 1);
      end
      bad <= 1'b1;
      repeat (2) @(posedge sof);
      bad <= 1'b0;
      cyc(40);
      check("lock lost", lock, 0);
      check("fault_n on loss", fault_n, 0);
      apb_xfer(1'b0, STAT_OFF, 0, 32'h2, 1'b0);
      apb_xfer(1'b1, STAT_OFF, 32'h2, 32'h0, 1'b0);
      apb_xfer(1'b0, STAT_OFF, 0, 32'h0, 1'b0);
      check("fault_n cleared", fault_n, 1);
      $display("test loss of alignment done");
      print_verdict();
   end
endmodule : test_h261_frame_aligner
